// File: hw/ecc_fault_pkg.sv
// register map, field layout and helpers for the ecc fault capture and inject block
package ecc_fault_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [31:0] OFS_STATUS      = 32'h0000_0000;
	localparam logic [31:0] OFS_IRQ_ENABLE  = 32'h0000_0004;
	localparam logic [31:0] OFS_CORR_ON     = 32'h0000_0008;
	localparam logic [31:0] OFS_CORR_COUNT  = 32'h0000_000C;
	localparam logic [31:0] OFS_CE_DATA     = 32'h0000_0100;
	localparam logic [31:0] OFS_CE_CHECK    = 32'h0000_0180;
	localparam logic [31:0] OFS_CE_ADDR     = 32'h0000_01C0;
	localparam logic [31:0] OFS_UE_DATA     = 32'h0000_0200;
	localparam logic [31:0] OFS_UE_CHECK    = 32'h0000_0280;
	localparam logic [31:0] OFS_UE_ADDR     = 32'h0000_02C0;
	localparam logic [31:0] OFS_INJ_DATA    = 32'h0000_0300;
	localparam logic [31:0] OFS_INJ_CHECK   = 32'h0000_0380;

	// ----------------------------------------------------------------
	// fields and reset values
	// ----------------------------------------------------------------
	localparam int          BIT_CE          = 1;
	localparam int          BIT_UE          = 0;
	localparam int          BIT_CORR_ON     = 0;
	localparam int          CNT_W           = 8;
	localparam logic [7:0]  CNT_MAX         = 8'hFF;
	localparam logic [1:0]  STATUS_RST      = 2'h0;
	localparam logic [1:0]  IRQ_ENABLE_RST  = 2'h0;
	localparam logic [7:0]  CNT_RST         = 8'h00;
	localparam logic [31:0] UNMAPPED_READ   = 32'hDEAD_DEAD;
	localparam int          BUS_W           = 32;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// count saturates instead of wrapping
	function automatic logic [7:0] sat_add(input logic [7:0] base, input logic [8:0] inc);
		logic [8:0] sum;
		sum = {1'b0, base} + inc;
		sat_add = sum > {1'b0, CNT_MAX} ? CNT_MAX : sum[7:0];
	endfunction : sat_add

	// index of the lowest flagged beat
	function automatic int first_set(input logic [7:0] vec);
		first_set = 0;
		for (int i = 7; i >= 0; i--) begin
			if (vec[i]) begin
				first_set = i;
			end
		end
	endfunction : first_set

	function automatic logic [8:0] ones(input logic [7:0] vec);
		ones = 9'h000;
		for (int i = 0; i < 8; i++) begin
			ones = ones + {8'h00, vec[i]};
		end
	endfunction : ones

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
	                                           input logic [3:0] be);
		for (int i = 0; i < 4; i++) begin
			lane_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : lane_merge

endpackage : ecc_fault_pkg

// File: hw/ecc_inject_xor.sv
// xor fault injector on the first write beat after the encoder
`timescale 1ns/100ps
module ecc_inject_xor import ecc_fault_pkg::*; #(
	parameter int DATA_W = 64,
	parameter int ECC_W  = 8
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic [DATA_W-1:0] data_pat,
	input  wire logic [ECC_W-1:0]  check_pat,
	input  wire logic              beat_valid,
	input  wire logic              first_beat,
	input  wire logic [DATA_W-1:0] data_in,
	input  wire logic [ECC_W-1:0]  check_in,
	output logic      [DATA_W-1:0] data_out,
	output logic      [ECC_W-1:0]  check_out,
	output logic                   valid_out,
	output logic                   applied
);

	logic hit_first;

	assign hit_first = beat_valid & first_beat;
	// only a first beat carries a pattern
	assign applied   = hit_first & ((|data_pat) | (|check_pat));

	// xor after encoding, registered toward the phy
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_out  <= '0;
			check_out <= '0;
			valid_out <= 1'b0;
		end else begin
			data_out  <= hit_first ? data_in ^ data_pat : data_in;
			check_out <= hit_first ? check_in ^ check_pat : check_in;
			valid_out <= beat_valid;
		end
	end

	a_inject_xor_first: assert property (@(posedge clk) disable iff (!arst_n)
		hit_first |=> data_out == $past(data_in ^ data_pat)
		              && check_out == $past(check_in ^ check_pat))
		else $error("first beat not xored with pattern");

	a_later_beat_clean: assert property (@(posedge clk) disable iff (!arst_n)
		beat_valid && !first_beat |=> data_out == $past(data_in) && valid_out)
		else $error("non-first beat was altered");

endmodule : ecc_inject_xor

// File: hw/ecc_fault_capture_inject.sv
// ecc fault capture banks, error counter, injector and avalon register slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
module ecc_fault_capture_inject import ecc_fault_pkg::*; #(
	parameter int         DATA_W                     = 64,
	parameter int         ECC_W                      = 8,
	parameter int         BEATS                      = 8,
	parameter int         ERR_ADDR_W                 = 32,
	parameter bit         correction_enable_at_reset = 1'b1,
	parameter bit         INJECT_PRESENT             = 1'b0
) (
	input  wire logic                      clk,
	input  wire logic                      arst_n,
	input  wire logic [BUS_W-1:0]          avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [BUS_W-1:0]          avs_writedata,
	input  wire logic [3:0]                avs_byteenable,
	output logic      [BUS_W-1:0]          avs_readdata,
	output logic                           avs_waitrequest,
	input  wire logic [BEATS-1:0]          ecc_single,
	input  wire logic [BEATS-1:0]          ecc_multiple,
	input  wire logic [ERR_ADDR_W-1:0]     ecc_err_addr,
	input  wire logic [BEATS*DATA_W-1:0]   ecc_rd_data,
	input  wire logic [BEATS*ECC_W-1:0]    ecc_rd_check,
	output logic                           correct_en,
	input  wire logic                      wr_beat_valid,
	input  wire logic                      wr_first_beat,
	input  wire logic [DATA_W-1:0]         wr_data_in,
	input  wire logic [ECC_W-1:0]          wr_check_in,
	output logic      [DATA_W-1:0]         wr_data_out,
	output logic      [ECC_W-1:0]          wr_check_out,
	output logic                           wr_valid_out,
	output logic                           interrupt
);

	localparam int DWORDS     = DATA_W / 32;
	localparam int BYTE_SHIFT = $clog2(DATA_W / 8);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic                    ack_ff;
	logic [BUS_W-1:0]        rdata_ff;
	logic [1:0]              status_ff;
	logic [1:0]              irq_en_ff;
	logic                    corr_on_ff;
	logic [CNT_W-1:0]        corr_error_counter;
	logic [DATA_W-1:0]       corr_first_fail_data;
	logic [ECC_W-1:0]        corr_first_fail_checkbits;
	logic [63:0]             corr_first_fail_address;
	logic [DATA_W-1:0]       uncorr_first_fail_data;
	logic [ECC_W-1:0]        uncorr_first_fail_checkbits;
	logic [63:0]             uncorr_first_fail_address;
	logic [DATA_W-1:0]       inject_data_pattern;
	logic [ECC_W-1:0]        inject_checkbit_pattern;
	logic                    irq_ff;

	logic                    wr_go;
	logic                    ce_hit;
	logic                    ue_hit;
	logic                    ce_take;
	logic                    ue_take;
	logic                    inj_applied;
	logic [1:0]              status_clr;
	logic [7:0]              ce_vec;
	logic [7:0]              ue_vec;
	logic [BUS_W-1:0]        nxt_rdata;

	// ----------------------------------------------------------------
	// avalon slave handshake
	// ----------------------------------------------------------------
	// one wait state, then the request is taken on the next edge
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign wr_go           = avs_write & ack_ff;
	assign avs_readdata    = rdata_ff;

	// bus and registers share the controller clock and reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= (avs_read | avs_write) & ~ack_ff;
		end
	end

	function automatic logic hit(input logic [31:0] base, input int words);
		hit = avs_address >= base && avs_address < base + 32'(words * 4);
	endfunction : hit

	function automatic int widx(input logic [31:0] base);
		widx = int'((avs_address - base) >> 2);
	endfunction : widx

	// 32-bit address decode; unmapped and write-only read as a marker
	always_comb begin
		nxt_rdata = UNMAPPED_READ;
		if (avs_address == OFS_STATUS) begin
			nxt_rdata = {30'h0, status_ff};
		end else if (avs_address == OFS_IRQ_ENABLE) begin
			nxt_rdata = {30'h0, irq_en_ff};
		end else if (avs_address == OFS_CORR_ON) begin
			nxt_rdata = {31'h0, corr_on_ff};
		end else if (avs_address == OFS_CORR_COUNT) begin
			nxt_rdata = {24'h0, corr_error_counter};
		end else if (hit(OFS_CE_DATA, DWORDS)) begin
			nxt_rdata = corr_first_fail_data[widx(OFS_CE_DATA)*32 +: 32];
		end else if (avs_address == OFS_CE_CHECK) begin
			nxt_rdata = 32'(corr_first_fail_checkbits);
		end else if (hit(OFS_CE_ADDR, 2)) begin
			nxt_rdata = corr_first_fail_address[widx(OFS_CE_ADDR)*32 +: 32];
		end else if (hit(OFS_UE_DATA, DWORDS)) begin
			nxt_rdata = uncorr_first_fail_data[widx(OFS_UE_DATA)*32 +: 32];
		end else if (avs_address == OFS_UE_CHECK) begin
			nxt_rdata = 32'(uncorr_first_fail_checkbits);
		end else if (hit(OFS_UE_ADDR, 2)) begin
			nxt_rdata = uncorr_first_fail_address[widx(OFS_UE_ADDR)*32 +: 32];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_ff <= '0;
		end else if (avs_read && !ack_ff) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// correction state at reset comes from the build parameter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			corr_on_ff <= correction_enable_at_reset;
			irq_en_ff  <= IRQ_ENABLE_RST;
		end else if (wr_go && avs_byteenable[0]) begin
			if (avs_address == OFS_CORR_ON) begin
				corr_on_ff <= avs_writedata[BIT_CORR_ON];
			end
			if (avs_address == OFS_IRQ_ENABLE) begin
				irq_en_ff <= avs_writedata[1:0];
			end
		end
	end

	assign correct_en = corr_on_ff;

	// ----------------------------------------------------------------
	// error detection and status
	// ----------------------------------------------------------------
	assign ce_vec  = 8'(ecc_single);
	assign ue_vec  = 8'(ecc_multiple);
	// nothing is recorded while correction is off
	assign ce_hit  = corr_on_ff & (|ce_vec);
	assign ue_hit  = corr_on_ff & (|ue_vec);
	// capture only while the bank holds nothing
	assign ce_take = ce_hit & ~status_ff[BIT_CE];
	assign ue_take = ue_hit & ~status_ff[BIT_UE];

	assign status_clr = (wr_go && avs_address == OFS_STATUS && avs_byteenable[0])
	                    ? avs_writedata[1:0] : 2'h0;

	// new errors win over a clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_ff <= STATUS_RST;
		end else begin
			status_ff[BIT_CE] <= (status_ff[BIT_CE] & ~status_clr[BIT_CE]) | ce_hit;
			status_ff[BIT_UE] <= (status_ff[BIT_UE] & ~status_clr[BIT_UE]) | ue_hit;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			corr_error_counter <= CNT_RST;
		end else if (wr_go && avs_address == OFS_CORR_COUNT && avs_byteenable[0]) begin
			corr_error_counter <= sat_add(avs_writedata[7:0], ce_hit ? ones(ce_vec) : 9'h000);
		end else if (ce_hit) begin
			corr_error_counter <= sat_add(corr_error_counter, ones(ce_vec));
		end
	end

	// ----------------------------------------------------------------
	// capture banks
	// ----------------------------------------------------------------
	// correctable bank, byte address of the first failing beat
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			corr_first_fail_data      <= '0;
			corr_first_fail_checkbits <= '0;
			corr_first_fail_address   <= '0;
		end else if (ce_take) begin
			corr_first_fail_data      <= ecc_rd_data[first_set(ce_vec)*DATA_W +: DATA_W];
			corr_first_fail_checkbits <= ecc_rd_check[first_set(ce_vec)*ECC_W +: ECC_W];
			corr_first_fail_address   <= (64'(ecc_err_addr) << BYTE_SHIFT)
			                             + 64'(first_set(ce_vec) * (DATA_W / 8));
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			uncorr_first_fail_data      <= '0;
			uncorr_first_fail_checkbits <= '0;
			uncorr_first_fail_address   <= '0;
		end else if (ue_take) begin
			uncorr_first_fail_data      <= ecc_rd_data[first_set(ue_vec)*DATA_W +: DATA_W];
			uncorr_first_fail_checkbits <= ecc_rd_check[first_set(ue_vec)*ECC_W +: ECC_W];
			uncorr_first_fail_address   <= (64'(ecc_err_addr) << BYTE_SHIFT)
			                               + 64'(first_set(ue_vec) * (DATA_W / 8));
		end
	end

	// ----------------------------------------------------------------
	// injection patterns
	// ----------------------------------------------------------------
	// present only in test builds, data pattern writes gated by correction, self clearing
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			inject_data_pattern     <= '0;
			inject_checkbit_pattern <= '0;
		end else if (INJECT_PRESENT) begin
			if (inj_applied) begin
				inject_data_pattern     <= '0;
				inject_checkbit_pattern <= '0;
			end
			for (int w = 0; w < DWORDS; w++) begin
				if (wr_go && corr_on_ff && avs_address == OFS_INJ_DATA + 32'(w * 4)) begin
					inject_data_pattern[w*32 +: 32] <=
						lane_merge(inject_data_pattern[w*32 +: 32], avs_writedata, avs_byteenable);
				end
			end
			if (wr_go && avs_address == OFS_INJ_CHECK) begin
				inject_checkbit_pattern <= ECC_W'(avs_writedata);
			end
		end
	end

	ecc_inject_xor #(
		.DATA_W     (DATA_W),
		.ECC_W      (ECC_W)
	) u_inject (
		.clk        (clk),
		.arst_n     (arst_n),
		.data_pat   (inject_data_pattern),
		.check_pat  (inject_checkbit_pattern),
		.beat_valid (wr_beat_valid),
		.first_beat (wr_first_beat),
		.data_in    (wr_data_in),
		.check_in   (wr_check_in),
		.data_out   (wr_data_out),
		.check_out  (wr_check_out),
		.valid_out  (wr_valid_out),
		.applied    (inj_applied)
	);

	// ----------------------------------------------------------------
	// interrupt
	// ----------------------------------------------------------------
	// level from enabled sticky status
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(status_ff & irq_en_ff);
		end
	end

	assign interrupt = irq_ff;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_req_waits;
		(avs_read || avs_write) && !ack_ff ##0 avs_waitrequest;
	endsequence
	sequence s_req_taken;
		##1 !avs_waitrequest;
	endsequence

	a_bus_one_wait: assert property (
		s_req_waits |-> s_req_taken)
		else $error("request not taken after one wait state");

	a_count_inc: assert property (
		ce_hit && $onehot(ecc_single) && corr_error_counter != CNT_MAX && !wr_go
		|=> corr_error_counter == $past(corr_error_counter) + 8'h01)
		else $error("counter did not step on a correctable error");

	a_count_saturate: assert property (
		corr_error_counter == CNT_MAX && !wr_go |=> corr_error_counter == CNT_MAX)
		else $error("counter left its maximum");

	a_off_frozen: assert property (
		!corr_on_ff && !wr_go |=> $stable(status_ff) && $stable(corr_error_counter))
		else $error("status or counter moved with correction off");

	a_first_kept: assert property (
		status_ff[BIT_CE] && !(wr_go && avs_address == OFS_STATUS)
		|=> $stable(corr_first_fail_data) [*2])
		else $error("later correctable beat overwrote capture");

	a_ce_capture: assert property (
		ce_take && ecc_single[0]
		|=> corr_first_fail_data == $past(ecc_rd_data[DATA_W-1:0]) && status_ff[BIT_CE])
		else $error("correctable bank missed the first beat");

	a_set_wins: assert property (
		ue_hit && status_clr[BIT_UE] |=> status_ff[BIT_UE])
		else $error("uncorrectable flag lost to a clear");

	a_irq_follow: assert property (
		|(status_ff & irq_en_ff) |=> interrupt)
		else $error("interrupt missing for enabled status");

	a_inject_clear: assert property (
		inj_applied && !wr_go |=> inject_data_pattern == '0 && inject_checkbit_pattern == '0)
		else $error("pattern not cleared after injection");

endmodule : ecc_fault_capture_inject

// File: bench/mem_err_model.sv
// memory controller side model: error flags, failing address and raw read beats
`timescale 1ns/100ps
module mem_err_model #(
	parameter int BEATS = 8
) (
	input  wire logic [BEATS-1:0]    s_req,
	input  wire logic [BEATS-1:0]    m_req,
	input  wire logic [31:0]         a_req,
	output logic      [BEATS-1:0]    ecc_single,
	output logic      [BEATS-1:0]    ecc_multiple,
	output logic      [31:0]         ecc_err_addr,
	output logic      [BEATS*64-1:0] ecc_rd_data,
	output logic      [BEATS*8-1:0]  ecc_rd_check
);
	// ----------------------------------------------------------------
	// address and beats are only valid with a flag; otherwise inverted junk
	// ----------------------------------------------------------------
	always_comb begin
		ecc_single   = s_req;
		ecc_multiple = m_req;
		ecc_err_addr = (|{s_req, m_req}) ? a_req : ~a_req;
		for (int i = 0; i < BEATS; i++) begin
			ecc_rd_data[i*64 +: 64] = {8{8'(i)}} ^ 64'h0123_4567_89AB_CDEF;
			ecc_rd_check[i*8 +: 8]  = 8'(i) ^ 8'h5A;
			if (!(|{s_req, m_req})) begin
				ecc_rd_data[i*64 +: 64] = ~ecc_rd_data[i*64 +: 64];
				ecc_rd_check[i*8 +: 8]  = ~ecc_rd_check[i*8 +: 8];
			end
		end
	end
endmodule : mem_err_model

// File: bench/tb_top.sv
// self-checking bench for the ecc fault capture and inject block
`timescale 1ns/100ps
module tb_top import ecc_fault_pkg::*;;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [31:0] avs_address = 32'h0, avs_writedata = 32'h0, avs_readdata, rd;
	logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [7:0]  s_req = 8'h00, m_req = 8'h00, ecc_single, ecc_multiple;
	logic [31:0] a_req = 32'h0, ecc_err_addr;
	logic [511:0] ecc_rd_data;
	logic [63:0] ecc_rd_check, wr_data_in = 64'h0, wr_data_out;
	logic [7:0]  wr_check_in = 8'h00, wr_check_out;
	logic        wr_beat_valid = 1'b0, wr_first_beat = 1'b0, wr_valid_out;
	logic        correct_en, interrupt;
	int          fail_count = 0, comparisons = 0, cycles = 0;

	always #12.5 clk = ~clk;

	mem_err_model model_u (.s_req(s_req), .m_req(m_req), .a_req(a_req),
		.ecc_single(ecc_single), .ecc_multiple(ecc_multiple), .ecc_err_addr(ecc_err_addr),
		.ecc_rd_data(ecc_rd_data), .ecc_rd_check(ecc_rd_check));

	ecc_fault_capture_inject #(.INJECT_PRESENT(1'b1)) dut_u (.clk(clk), .arst_n(arst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ecc_single(ecc_single), .ecc_multiple(ecc_multiple), .ecc_err_addr(ecc_err_addr),
		.ecc_rd_data(ecc_rd_data), .ecc_rd_check(ecc_rd_check), .correct_en(correct_en),
		.wr_beat_valid(wr_beat_valid), .wr_first_beat(wr_first_beat),
		.wr_data_in(wr_data_in), .wr_check_in(wr_check_in), .wr_data_out(wr_data_out),
		.wr_check_out(wr_check_out), .wr_valid_out(wr_valid_out), .interrupt(interrupt));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic close_out;
		if (fail_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// request held until waitrequest sampled low
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= !wr;
		avs_write     <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus

	task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, {32'h0, exp}, {32'h0, rd});
	endtask : rchk

	task automatic fire(input logic [7:0] s, input logic [7:0] m, input logic [31:0] a);
		@(posedge clk);
		s_req <= s;
		m_req <= m;
		a_req <= a;
		@(posedge clk);
		s_req <= 8'h00;
		m_req <= 8'h00;
	endtask : fire

	task automatic beat(input logic first, input logic [63:0] d, input logic [7:0] c,
	                    input logic [63:0] ed, input logic [7:0] ec);
		@(posedge clk);
		wr_beat_valid <= 1'b1;
		wr_first_beat <= first;
		wr_data_in    <= d;
		wr_check_in   <= c;
		@(posedge clk);
		wr_beat_valid <= 1'b0;
		@(negedge clk);
		chk("wr_valid_out", 64'h1, {63'h0, wr_valid_out});
		chk("wr_data_out", ed, wr_data_out);
		chk("wr_check_out", {56'h0, ec}, {56'h0, wr_check_out});
	endtask : beat

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		chk("correct_en", 64'h1, {63'h0, correct_en});
		rchk("status", OFS_STATUS, 32'h0);
		rchk("irq_enable", OFS_IRQ_ENABLE, 32'h0);
		rchk("corr_on", OFS_CORR_ON, 32'h1);
		rchk("count", OFS_CORR_COUNT, 32'h0);
		rchk("inject_data_pattern", OFS_INJ_DATA, UNMAPPED_READ);
		rchk("reserved", 32'h0000_0010, UNMAPPED_READ);
	endtask : t_reset

	task automatic t_corr;
		bus(1'b1, OFS_IRQ_ENABLE, 32'h2);
		fire(8'h24, 8'h00, 32'h0000_1000);
		fire(8'h01, 8'h00, 32'h0000_2000);
		repeat (2) @(negedge clk);
		chk("interrupt", 64'h1, {63'h0, interrupt});
		rchk("status", OFS_STATUS, 32'h2);
		rchk("count", OFS_CORR_COUNT, 32'h3);
		rchk("corr_first_fail_address", OFS_CE_ADDR, (32'h1000 << 3) + 32'h10);
		rchk("corr_first_fail_address hi", OFS_CE_ADDR + 4, 32'h0);
		rchk("corr_first_fail_data lo", OFS_CE_DATA, 32'h89AB_CDEF ^ 32'h0202_0202);
		rchk("corr_first_fail_data hi", OFS_CE_DATA + 4, 32'h0123_4567 ^ 32'h0202_0202);
		rchk("corr_first_fail_checkbits", OFS_CE_CHECK, 32'h58);
		bus(1'b1, OFS_STATUS, 32'h2);
		repeat (3) @(negedge clk);
		chk("interrupt clear", 64'h0, {63'h0, interrupt});
	endtask : t_corr

	task automatic t_uncorr;
		fire(8'h00, 8'h06, 32'h0000_0020);
		repeat (2) @(negedge clk);
		chk("interrupt masked", 64'h0, {63'h0, interrupt});
		rchk("status", OFS_STATUS, 32'h1);
		rchk("count", OFS_CORR_COUNT, 32'h3);
		rchk("uncorr_first_fail_address", OFS_UE_ADDR, (32'h20 << 3) + 32'h8);
		rchk("uncorr_first_fail_data", OFS_UE_DATA, 32'h89AB_CDEF ^ 32'h0101_0101);
		rchk("uncorr_first_fail_checkbits", OFS_UE_CHECK, 32'h5B);
		rchk("corr bank kept", OFS_CE_CHECK, 32'h58);
		bus(1'b1, OFS_STATUS, 32'h1);
		rchk("status cleared", OFS_STATUS, 32'h0);
		// flag and clear meet at one edge: the new error must stay flagged
		fork
			bus(1'b1, OFS_STATUS, 32'h1);
			begin
				@(posedge clk);
				fire(8'h00, 8'h01, 32'h0000_0020);
			end
		join
		rchk("status set wins", OFS_STATUS, 32'h1);
		bus(1'b1, OFS_STATUS, 32'h1);
	endtask : t_uncorr

	task automatic t_saturate;
		bus(1'b1, OFS_CORR_COUNT, 32'hFE);
		fire(8'h03, 8'h00, 32'h0);
		rchk("count max", OFS_CORR_COUNT, 32'hFF);
		fire(8'h01, 8'h00, 32'h0);
		rchk("count no wrap", OFS_CORR_COUNT, 32'hFF);
		bus(1'b1, OFS_STATUS, 32'h3);
	endtask : t_saturate

	task automatic t_off;
		bus(1'b1, OFS_CORR_ON, 32'h0);
		@(negedge clk);
		chk("correct_en off", 64'h0, {63'h0, correct_en});
		fire(8'h01, 8'h01, 32'h0000_0040);
		rchk("status frozen", OFS_STATUS, 32'h0);
		rchk("count frozen", OFS_CORR_COUNT, 32'hFF);
		bus(1'b1, OFS_INJ_DATA, 32'hFFFF_FFFF);
		bus(1'b1, OFS_CORR_ON, 32'h1);
		beat(1'b1, 64'h1111_2222_3333_4444, 8'h77, 64'h1111_2222_3333_4444, 8'h77);
	endtask : t_off

	task automatic t_inject;
		// only lane 0 is enabled, so the upper bytes must not land
		@(posedge clk);
		avs_byteenable <= 4'h1;
		bus(1'b1, OFS_INJ_DATA, 32'h1234_56FF);
		avs_byteenable <= 4'hF;
		bus(1'b1, OFS_INJ_DATA + 4, 32'h8000_0000);
		bus(1'b1, OFS_INJ_CHECK, 32'h81);
		beat(1'b0, 64'hA5A5_0000_0000_5A5A, 8'h0F, 64'hA5A5_0000_0000_5A5A, 8'h0F);
		beat(1'b1, 64'hA5A5_0000_0000_5A5A, 8'h0F, 64'h25A5_0000_0000_5AA5, 8'h8E);
		beat(1'b1, 64'hA5A5_0000_0000_5A5A, 8'h0F, 64'hA5A5_0000_0000_5A5A, 8'h0F);
	endtask : t_inject

	// ----------------------------------------------------------------
	// main sequence and timeout
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			close_out();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		t_reset();
		t_corr();
		t_uncorr();
		t_saturate();
		t_off();
		t_inject();
		close_out();
	end
endmodule : tb_top
